// ### rtl/drive_power_state_control.sv
// Purpose: Command word decode and power state sequencing with brake
// Assumes: Object accesses are single-cycle strobes, inputs synchronous
// Notes:   Motion profiles live elsewhere; this block gates them
`timescale 1ns/10ps
`include "drive_power_defines.svh"
module drive_power_state_control #(
	parameter int unsigned CLK_PER_MS = `CLK_PER_MS
) (
	// Clock and reset
	input  wire logic        ref_clk,
	input  wire logic        resetn,
	// Object access
	input  wire logic        obj_wr,
	input  wire logic        obj_rd,
	input  wire logic [15:0] obj_index,
	input  wire logic [15:0] obj_wdata,
	output logic      [15:0] obj_rdata_q,
	// Power-up options
	input  wire logic        tpdo_enable_opt,
	input  wire logic        auto_enable_opt,
	// Brake configuration
	input  wire logic [2:0]  brake_io_sel,
	input  wire logic        brake_release_level,
	input  wire drive_power_pkg::ms_t brake_activate_ms,
	input  wire drive_power_pkg::ms_t brake_release_ms,
	// I/O lines
	input  wire logic [7:1]  io_in,
	input  wire logic [7:1]  io_out_mask,
	input  wire logic [1:0]  limit_enable,
	output logic      [7:1]  io_out_q,
	// Drive feedback
	input  wire logic        fault_in,
	input  wire logic        homing_done,
	input  wire logic [15:0] pos_error_mag,
	input  wire logic [15:0] max_pos_error,
	// Drive control
	output logic      [15:0] status_word_q,
	output logic      [7:0]  mode_display_q,
	output logic             power_on_q,
	output logic             drive_enable,
	output logic             motion_allowed_q,
	output logic             halt_q,
	output logic             quick_stop_q,
	output logic      [3:0]  mode_ctrl_q,
	output logic             encoder_follow_q,
	output logic             motion_error_q,
	output logic             tpdo_active_q,
	output logic             home_switch_q
);
	import drive_power_pkg::*;

	brake_seq_if br ();

	pds_state_e state_q;
	pds_state_e target_q;
	logic [15:0] cmd_q;
	logic        cmd_prev_q;
	logic [7:0]  mode_q;
	logic [7:1]  io_word_q;
	cmd_e        cmd;
	logic        fault_rise;
	logic        limit_hit;
	logic [7:1]  brake_bit;
	logic        fault_take;

	// One-hot of the brake line; line zero means no brake
	function automatic logic [7:1] brake_onehot(input logic [2:0] sel);
		logic [7:1] oh;
		oh = '0;
		for (int i = 1; i <= 7; i++)
			oh[i] = (sel == 3'(i));
		return oh;
	endfunction

	// Bit 7 high blocks every other command
	function automatic cmd_e cmd_decode(input logic [15:0] cw);
		if (cw[`CW_FAULT_RESET])
			return CMD_NONE;
		else if (!cw[`CW_ENABLE_VOLT])
			return CMD_DISABLE_VOLT;
		else if (!cw[`CW_QUICK_STOP])
			return CMD_QUICK_STOP;
		else if (!cw[`CW_SWITCH_ON])
			return CMD_SHUTDOWN;
		else if (cw[`CW_ENABLE_OP])
			return CMD_ENABLE_OP;
		else
			return CMD_SWITCH_ON;
	endfunction

	function automatic logic [15:0] state_bits(input pds_state_e s);
		logic [15:0] w;
		w = `WORD_ZERO;
		unique case (s)
			ST_NOT_READY: ;
			ST_SWITCH_DISABLED: w[`SW_SO_DISABLED] = 1'b1;
			ST_READY: begin
				w[`SW_QS_OFF] = 1'b1;
				w[`SW_READY]  = 1'b1;
			end
			ST_SWITCHED_ON, ST_OP_ENABLED: begin
				w[`SW_QS_OFF]      = 1'b1;
				w[`SW_READY]       = 1'b1;
				w[`SW_SWITCHED_ON] = 1'b1;
				w[`SW_OP_EN]       = (s == ST_OP_ENABLED);
			end
			ST_QUICK_STOP: begin
				w[`SW_READY]       = 1'b1;
				w[`SW_SWITCHED_ON] = 1'b1;
				w[`SW_OP_EN]       = 1'b1;
			end
			ST_FAULT_REACTION: begin
				w[`SW_FAULT]       = 1'b1;
				w[`SW_OP_EN]       = 1'b1;
				w[`SW_SWITCHED_ON] = 1'b1;
				w[`SW_READY]       = 1'b1;
			end
			ST_FAULT: w[`SW_FAULT] = 1'b1;
		endcase
		w[`SW_VOLT] = (s == ST_SWITCHED_ON || s == ST_OP_ENABLED || s == ST_QUICK_STOP);
		return w;
	endfunction

	assign cmd        = cmd_decode(cmd_q); // [R2] [R3] [R22]
	assign fault_rise = cmd_q[`CW_FAULT_RESET] && !cmd_prev_q; // [R1]
	assign limit_hit  = (limit_enable[0] && io_in[`IO_NEG_LIMIT]) ||
		(limit_enable[1] && io_in[`IO_POS_LIMIT]); // [R18]
	assign brake_bit  = brake_onehot(brake_io_sel);
	assign fault_take = fault_in && state_q != ST_FAULT_REACTION &&
		state_q != ST_FAULT && target_q != ST_FAULT;

	assign br.want       = (target_q == ST_OP_ENABLED || target_q == ST_QUICK_STOP);
	assign br.configured = (brake_io_sel != `BRAKE_NONE); // [R10]
	assign br.act_ms     = brake_activate_ms;
	assign br.rel_ms     = brake_release_ms;
	assign drive_enable  = br.drive_on;

	brake_sequencer #(
		.CLK_PER_MS (CLK_PER_MS)
	) u_brake (
		.ref_clk (ref_clk),
		.resetn  (resetn),
		.br      (br)
	);

	// Object writes; command bits 15..10 are kept but drive nothing
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			cmd_q      <= `CMD_RESET;
			cmd_prev_q <= 1'b0;
			mode_q     <= `MODE_RESET;
			io_word_q  <= `IO_RESET;
		end else begin
			cmd_prev_q <= cmd_q[`CW_FAULT_RESET];
			if (obj_wr && obj_index == `OBJ_CMD_WORD)
				cmd_q <= obj_wdata; // [R6] [R21]
			if (obj_wr && obj_index == `OBJ_MODE)
				mode_q <= obj_wdata[7:0]; // [R5]
			if (obj_wr && obj_index == `OBJ_OUT_WORD)
				io_word_q <= (io_word_q & (io_out_mask | brake_bit)) |
					(obj_wdata[7:1] & ~(io_out_mask | brake_bit)); // [R14]
		end
	end

	// Object reads; the output word never shows the brake level
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			obj_rdata_q <= `WORD_ZERO;
		else if (obj_rd) begin
			unique case (obj_index)
				`OBJ_CMD_WORD:    obj_rdata_q <= cmd_q;
				`OBJ_STATUS_WORD: obj_rdata_q <= status_word_q;
				`OBJ_MODE:        obj_rdata_q <= {8'h00, mode_q};
				`OBJ_MODE_DISP:   obj_rdata_q <= {8'h00, mode_display_q};
				`OBJ_OUT_WORD:    obj_rdata_q <= {8'h00, io_word_q, 1'b0}; // [R14]
				default:          obj_rdata_q <= `WORD_ZERO;
			endcase
		end
	end

	// Power sequence: target moves on command, shown state follows on completion
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			state_q  <= ST_NOT_READY;
			target_q <= ST_NOT_READY;
		end else if (fault_take) begin
			state_q  <= ST_FAULT_REACTION; // [R8]
			target_q <= ST_FAULT;
		end else if (target_q != state_q) begin
			if (br.settled) begin // [R7] [R24]
				if (target_q == ST_OP_ENABLED && state_q != ST_QUICK_STOP && limit_hit) begin
					state_q  <= ST_FAULT_REACTION; // [R17]
					target_q <= ST_FAULT;
				end else
					state_q <= target_q; // [R7] [R8]
			end
		end else begin
			unique case (state_q)
				ST_NOT_READY:
					target_q <= auto_enable_opt ? ST_OP_ENABLED : ST_SWITCH_DISABLED; // [R16]
				ST_SWITCH_DISABLED:
					if (cmd == CMD_SHUTDOWN)
						target_q <= ST_READY;
				ST_READY:
					if (cmd == CMD_SWITCH_ON)
						target_q <= ST_SWITCHED_ON;
					else if (cmd == CMD_ENABLE_OP)
						target_q <= ST_OP_ENABLED;
					else if (cmd == CMD_DISABLE_VOLT || cmd == CMD_QUICK_STOP)
						target_q <= ST_SWITCH_DISABLED;
				ST_SWITCHED_ON:
					if (cmd == CMD_ENABLE_OP)
						target_q <= ST_OP_ENABLED;
					else if (cmd == CMD_SHUTDOWN)
						target_q <= ST_READY;
					else if (cmd == CMD_DISABLE_VOLT || cmd == CMD_QUICK_STOP)
						target_q <= ST_SWITCH_DISABLED;
				ST_OP_ENABLED:
					if (cmd == CMD_SWITCH_ON)
						target_q <= ST_SWITCHED_ON;
					else if (cmd == CMD_SHUTDOWN)
						target_q <= ST_READY;
					else if (cmd == CMD_DISABLE_VOLT)
						target_q <= ST_SWITCH_DISABLED;
					else if (cmd == CMD_QUICK_STOP)
						target_q <= ST_QUICK_STOP;
				ST_QUICK_STOP:
					if (cmd == CMD_ENABLE_OP)
						target_q <= ST_OP_ENABLED;
					else if (cmd == CMD_DISABLE_VOLT)
						target_q <= ST_SWITCH_DISABLED;
				ST_FAULT_REACTION: ;
				ST_FAULT:
					// Reset only takes once the fault source is gone
					if (fault_rise && !fault_in)
						target_q <= ST_SWITCH_DISABLED; // [R1]
			endcase
			// Anything else is an invalid pattern for this state [R25]
		end
	end

	// Status and drive gating outputs
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			status_word_q    <= `WORD_ZERO;
			mode_display_q   <= `MODE_RESET;
			power_on_q       <= 1'b0;
			motion_allowed_q <= 1'b0;
			halt_q           <= 1'b0;
			quick_stop_q     <= 1'b0;
			mode_ctrl_q      <= 4'h0;
			encoder_follow_q <= 1'b0;
			home_switch_q    <= 1'b0;
		end else begin
			status_word_q <= state_bits(state_q); // [R23]
			status_word_q[`SW_REMOTE] <= 1'b1;
			status_word_q[`SW_HOMED]  <= homing_done; // [R9]
			mode_display_q   <= mode_q; // [R5]
			power_on_q       <= state_bits(state_q) >> `SW_VOLT != `WORD_ZERO &&
				(state_q == ST_SWITCHED_ON || state_q == ST_OP_ENABLED ||
				state_q == ST_QUICK_STOP);
			motion_allowed_q <= state_q == ST_OP_ENABLED && target_q == ST_OP_ENABLED; // [R12]
			halt_q           <= state_q == ST_OP_ENABLED && cmd_q[`CW_HALT]; // [R4]
			quick_stop_q     <= state_q == ST_QUICK_STOP;
			mode_ctrl_q      <= {cmd_q[`CW_MODE_HI], cmd_q[6:4]}; // [R5]
			encoder_follow_q <= mode_q == `MODE_ENC_FOLLOW; // [R20]
			home_switch_q    <= io_in[`IO_HOME]; // [R18]
		end
	end

	// Transmit objects option is caught while leaving reset
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			tpdo_active_q <= 1'b0;
		else if (state_q == ST_NOT_READY)
			tpdo_active_q <= tpdo_enable_opt; // [R15]
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			motion_error_q <= 1'b0;
		else
			motion_error_q <= pos_error_mag > max_pos_error; // [R19]
	end

	// Brake line gets its level from the sequencer, others from the word
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			io_out_q <= `IO_RESET;
		else
			io_out_q <= (io_word_q & ~brake_bit) |
				(brake_bit & {7{~(br.brake_released ^ brake_release_level)}}); // [R10] [R13]
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_steady_reset;
		(state_q == ST_FAULT && target_q == ST_FAULT && !fault_rise) |=> target_q == ST_FAULT;
	endproperty
	a_steady_reset: assert property (p_steady_reset) else $error("fault cleared without edge"); // [R1]

	property p_edge_reset;
		(state_q == ST_FAULT && target_q == ST_FAULT && fault_rise && !fault_in) |=>
			target_q == ST_SWITCH_DISABLED ##1 state_q == ST_SWITCH_DISABLED;
	endproperty
	a_edge_reset: assert property (p_edge_reset) else $error("fault reset not taken"); // [R1]

	property p_shown_on_done;
		!$stable(state_q) |-> $past(br.settled) || state_q == ST_FAULT_REACTION;
	endproperty
	a_shown_on_done: assert property (p_shown_on_done) else $error("state shown early"); // [R7]

	property p_fault_now;
		fault_take |=> state_q == ST_FAULT_REACTION && target_q == ST_FAULT;
	endproperty
	a_fault_now: assert property (p_fault_now) else $error("fault reaction not shown"); // [R8]

	property p_target_held;
		(target_q != state_q && !fault_in) |=> $stable(target_q) || target_q == ST_FAULT;
	endproperty
	a_target_held: assert property (p_target_held) else $error("command taken mid transition"); // [R24]

	property p_halt;
		(state_q == ST_OP_ENABLED && cmd_q[`CW_HALT]) |=> halt_q && status_word_q[`SW_OP_EN];
	endproperty
	a_halt: assert property (p_halt) else $error("halt not raised"); // [R4]

	property p_opena_code;
		state_q == ST_OP_ENABLED |=>
			{status_word_q[6:5], status_word_q[3:0]} == 6'b010111;
	endproperty
	a_opena_code: assert property (p_opena_code) else $error("bad state code"); // [R23]

	property p_no_brake;
		brake_io_sel == `BRAKE_NONE |=> io_out_q == $past(io_word_q);
	endproperty
	a_no_brake: assert property (p_no_brake) else $error("brake line driven"); // [R10]

	property p_brake_level;
		(brake_io_sel != `BRAKE_NONE && $stable(brake_io_sel)) |=>
			(io_out_q & brake_bit) == ($past(br.brake_released) == brake_release_level ?
			brake_bit : `IO_RESET);
	endproperty
	a_brake_level: assert property (p_brake_level) else $error("brake level wrong"); // [R13]

	property p_limit_fault;
		(target_q == ST_OP_ENABLED && state_q != ST_OP_ENABLED && state_q != ST_QUICK_STOP &&
			br.settled && limit_hit && !fault_take) |=> state_q == ST_FAULT_REACTION;
	endproperty
	a_limit_fault: assert property (p_limit_fault) else $error("limit fault missed"); // [R17]

	property p_motion_error;
		pos_error_mag > max_pos_error |=> motion_error_q;
	endproperty
	a_motion_error: assert property (p_motion_error) else $error("motion error missed"); // [R19]

endmodule

// ### rtl/drive_power_defines.svh
// Purpose: Constants for the drive power sequencer and brake sequencer
// Assumes: 50 MHz reference clock
// Notes:   Types live in drive_power_pkg
//
// What this block does
// R1: Fault cleared only on command bit 7 rise
// R2: Command bits 3..0 request state transitions
// R3: Bits: 3 enable op, 2 quick stop, 1 voltage, 0 switch-on
// R4: Bit 8 halts motion in operation enabled
// R5: Bits 9, 6..4 follow mode; mode echoed back
// R6: Bit 10 reserved; bits 15..11 unused
// R7: Shown state changes only after transition completes
// R8: Fault reaction shown at once, then fault
// R9: Status bit 14 shows homing completed
// R10: Brake output zero disables brake; else selects line
// R11: Disable: engage brake, wait, then drop drive
// R12: Enable: drive on, release brake, wait, allow motion
// R13: Brake release level selectable; opposite holds brake
// R14: Brake line hidden from and masked in output word
// R15: Power-up option enables default transmit objects
// R16: Power-up option jumps straight to operation enabled
// R17: Active limit on entering operation raises fault
// R18: Limits and home default to lines 1, 2, 3
// R19: Motion error when position error exceeds maximum
// R20: Mode minus one selects encoder following
// R21: Host writes command, reads status via objects
// R22: Command encodings on bits 7,3,2,1,0
// R23: State encoded on status bits 6,5,3,2,1,0
// R24: Finish one transition before taking next command
// R25: Invalid command pattern leaves state unchanged
`ifndef DRIVE_POWER_DEFINES_SVH
`define DRIVE_POWER_DEFINES_SVH

`define OBJ_CMD_WORD    16'h6040
`define OBJ_STATUS_WORD 16'h6041
`define OBJ_MODE        16'h6060
`define OBJ_MODE_DISP   16'h6061
`define OBJ_OUT_WORD    16'h60fe

`define CW_SWITCH_ON   0
`define CW_ENABLE_VOLT 1
`define CW_QUICK_STOP  2
`define CW_ENABLE_OP   3
`define CW_FAULT_RESET 7
`define CW_HALT        8
`define CW_MODE_HI     9

`define SW_READY       0
`define SW_SWITCHED_ON 1
`define SW_OP_EN       2
`define SW_FAULT       3
`define SW_VOLT        4
`define SW_QS_OFF      5
`define SW_SO_DISABLED 6
`define SW_REMOTE      9
`define SW_HOMED       14

`define MODE_ENC_FOLLOW 8'hff
`define IO_NEG_LIMIT    1
`define IO_POS_LIMIT    2
`define IO_HOME         3
`define BRAKE_NONE      3'h0

`define CMD_RESET   16'h0000
`define MODE_RESET  8'h00
`define IO_RESET    7'h00
`define WORD_ZERO   16'h0000

`define CLK_PERIOD_NS 20
`define MS_NS         1000000
`define CLK_PER_MS    (`MS_NS / `CLK_PERIOD_NS)

`endif

// ### rtl/drive_power_pkg.sv
// Purpose: Shared types of the drive power sequencer
// Assumes: Constants come from drive_power_defines.svh
// Notes:   Enums carry no explicit codes
package drive_power_pkg;

	typedef enum logic [2:0] {
		ST_NOT_READY,
		ST_SWITCH_DISABLED,
		ST_READY,
		ST_SWITCHED_ON,
		ST_OP_ENABLED,
		ST_QUICK_STOP,
		ST_FAULT_REACTION,
		ST_FAULT
	} pds_state_e;

	typedef enum logic [2:0] {
		CMD_NONE,
		CMD_SHUTDOWN,
		CMD_SWITCH_ON,
		CMD_DISABLE_VOLT,
		CMD_QUICK_STOP,
		CMD_ENABLE_OP
	} cmd_e;

	typedef enum logic [1:0] {
		BR_OFF,
		BR_RELEASE_WAIT,
		BR_ON,
		BR_ENGAGE_WAIT
	} brake_state_e;

	typedef logic [15:0] ms_t;

endpackage

// ### rtl/brake_seq_if.sv
// Purpose: Carrier between power sequencer and brake sequencer
// Assumes: One clock domain
// Notes:   settled is combinational from the sequencer
`timescale 1ns/10ps
interface brake_seq_if;
	import drive_power_pkg::*;
	logic want;
	logic configured;
	ms_t  act_ms;
	ms_t  rel_ms;
	logic drive_on;
	logic brake_released;
	logic settled;

	modport ctrl (output want, configured, act_ms, rel_ms,
		input drive_on, brake_released, settled);
	modport seq (input want, configured, act_ms, rel_ms,
		output drive_on, brake_released, settled);
endinterface

// ### rtl/brake_sequencer.sv
// Purpose: Orders drive enable and brake release with timed waits
// Assumes: Wait times in milliseconds, counted from ref_clk
// Notes:   An engage wait always runs to its end once begun
`timescale 1ns/10ps
`include "drive_power_defines.svh"
module brake_sequencer #(
	parameter int unsigned CLK_PER_MS = `CLK_PER_MS
) (
	// Clock and reset
	input  wire logic   ref_clk,
	input  wire logic   resetn,
	// Sequencer side
	brake_seq_if.seq    br
);
	import drive_power_pkg::*;

	localparam int PRE_W = $clog2(CLK_PER_MS) + 1;

	brake_state_e st_q;
	brake_state_e st_d;
	logic [PRE_W-1:0] pre_q;
	ms_t              ms_q;
	logic             elapsed;
	logic             drive_on_q;
	logic             released_q;

	assign elapsed = ms_q >= ((st_q == BR_RELEASE_WAIT) ? br.rel_ms : br.act_ms);
	assign br.settled = (st_q == BR_ON && br.want) || (st_q == BR_OFF && !br.want);
	assign br.drive_on = drive_on_q;
	assign br.brake_released = released_q;

	always_comb begin
		st_d = st_q;
		unique case (st_q)
			BR_OFF: begin
				if (br.want)
					st_d = br.configured ? BR_RELEASE_WAIT : BR_ON;
			end
			BR_RELEASE_WAIT: begin
				// Dropping out mid-release still engages and waits first
				if (!br.want)
					st_d = BR_ENGAGE_WAIT;
				else if (elapsed)
					st_d = BR_ON; // [R12]
			end
			BR_ON: begin
				if (!br.want)
					st_d = br.configured ? BR_ENGAGE_WAIT : BR_OFF; // [R11]
			end
			BR_ENGAGE_WAIT: begin
				if (elapsed)
					st_d = BR_OFF; // [R11]
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn)
			st_q <= BR_OFF;
		else
			st_q <= st_d;
	end

	// Prescaler restarts on entry so a wait is never short
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			pre_q <= '0;
			ms_q  <= '0;
		end else if (st_d != st_q) begin
			pre_q <= '0;
			ms_q  <= '0;
		end else if (pre_q == PRE_W'(CLK_PER_MS - 1)) begin
			pre_q <= '0;
			ms_q  <= ms_q + 16'h0001;
		end else begin
			pre_q <= pre_q + PRE_W'(1);
		end
	end

	// Drive comes on a cycle before the brake lets go
	always_ff @(posedge ref_clk or negedge resetn) begin
		if (!resetn) begin
			drive_on_q <= 1'b0;
			released_q <= 1'b0;
		end else begin
			drive_on_q <= st_d != BR_OFF; // [R11] [R12]
			released_q <= br.configured && (st_d == BR_ON ||
				(st_q == BR_RELEASE_WAIT && st_d == BR_RELEASE_WAIT)); // [R12]
		end
	end

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!resetn);

	property p_release_needs_drive;
		$rose(released_q) |-> drive_on_q && $past(drive_on_q);
	endproperty
	a_release_needs_drive: assert property (p_release_needs_drive) else $error("brake freed early"); // [R12]

	property p_drive_off_braked;
		($fell(drive_on_q) && br.configured) |-> !$past(released_q) && !$past(released_q, 2);
	endproperty
	a_drive_off_braked: assert property (p_drive_off_braked) else $error("drive off unbraked"); // [R11]

endmodule

// ### verification/fieldbus_master_model.sv
// Purpose: Fieldbus master stand-in that writes and reads drive objects
// Assumes: One strobe cycle per access, launched just after a rising edge
// Notes:   Idle index and data show the inverse of the last value
`timescale 1ns/10ps
module fieldbus_master_model (
	// Clock
	input  wire logic        ref_clk,
	// Object access
	output logic             obj_wr,
	output logic             obj_rd,
	output logic      [15:0] obj_index,
	output logic      [15:0] obj_wdata
);
	initial begin
		obj_wr = 1'b0;
		obj_rd = 1'b0;
		obj_index = 16'h0000;
		obj_wdata = 16'h0000;
	end

	// Confirmed and unconfirmed transfers look alike at this port
	task automatic access(input logic wr, input logic [15:0] idx, input logic [15:0] data);
		@(posedge ref_clk);
		#1;
		obj_wr = wr;
		obj_rd = ~wr;
		obj_index = idx;
		obj_wdata = data;
		@(posedge ref_clk);
		#1;
		obj_wr = 1'b0;
		obj_rd = 1'b0;
		obj_index = ~idx;
		obj_wdata = ~data;
	endtask
endmodule

// ### verification/drive_power_state_control_tb.sv
// Purpose: Self-checking bench of the power sequencer and brake sequencing
// Assumes: Short millisecond count so brake waits last a few cycles
// Notes:   State checks poll the status word under a bounded count
`timescale 1ns/10ps
module drive_power_state_control_tb;
	import drive_power_pkg::*;
	localparam int unsigned CPM   = 4;
	localparam logic [15:0] SMASK = 16'h006f;
	logic        ref_clk, resetn, obj_wr, obj_rd, fault_in, homing_done;
	logic [15:0] obj_index, obj_wdata, obj_rdata_q, status_word_q;
	logic        tpdo_enable_opt, auto_enable_opt, brake_release_level;
	logic [2:0]  brake_io_sel;
	ms_t         brake_activate_ms, brake_release_ms;
	logic [7:1]  io_in, io_out_mask, io_out_q;
	logic [1:0]  limit_enable;
	logic [15:0] pos_error_mag, max_pos_error;
	logic [7:0]  mode_display_q;
	logic        power_on_q, drive_enable, motion_allowed_q, halt_q, quick_stop_q;
	logic [3:0]  mode_ctrl_q;
	logic        encoder_follow_q, motion_error_q, tpdo_active_q, home_switch_q;
	int          n_mismatch = 0;
	int          total_checks = 0;
	int          cycles = 0;
	// Command beside the state bits it should leave behind
	logic [31:0] rows [16] = '{32'h0006_0021, 32'h0007_0023, 32'h000f_0027,
		32'h0007_0023, 32'h0006_0021, 32'h000f_0027, 32'h0002_0007, 32'h000f_0027,
		32'h0006_0021, 32'h0000_0040, 32'h0007_0040, 32'h0006_0021, 32'h0002_0040,
		32'h0006_0021, 32'h0007_0023, 32'h0000_0040};

	fieldbus_master_model host (.ref_clk(ref_clk), .obj_wr(obj_wr), .obj_rd(obj_rd),
		.obj_index(obj_index), .obj_wdata(obj_wdata));
	drive_power_state_control #(.CLK_PER_MS(CPM)) dut (
		.ref_clk(ref_clk), .resetn(resetn), .obj_wr(obj_wr), .obj_rd(obj_rd),
		.obj_index(obj_index), .obj_wdata(obj_wdata), .obj_rdata_q(obj_rdata_q),
		.tpdo_enable_opt(tpdo_enable_opt), .auto_enable_opt(auto_enable_opt),
		.brake_io_sel(brake_io_sel), .brake_release_level(brake_release_level),
		.brake_activate_ms(brake_activate_ms), .brake_release_ms(brake_release_ms),
		.io_in(io_in), .io_out_mask(io_out_mask), .limit_enable(limit_enable),
		.io_out_q(io_out_q), .fault_in(fault_in), .homing_done(homing_done),
		.pos_error_mag(pos_error_mag), .max_pos_error(max_pos_error),
		.status_word_q(status_word_q), .mode_display_q(mode_display_q),
		.power_on_q(power_on_q), .drive_enable(drive_enable),
		.motion_allowed_q(motion_allowed_q), .halt_q(halt_q), .quick_stop_q(quick_stop_q),
		.mode_ctrl_q(mode_ctrl_q), .encoder_follow_q(encoder_follow_q),
		.motion_error_q(motion_error_q), .tpdo_active_q(tpdo_active_q),
		.home_switch_q(home_switch_q));

	initial ref_clk = 1'b0;
	always #10 ref_clk = ~ref_clk;

	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			n_mismatch++;
			results();
		end
	end

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic wait_state(input logic [15:0] exp, input int settle);
		int i;
		i = 0;
		while ((status_word_q & SMASK) !== exp && i < 300) begin
			@(posedge ref_clk);
			#1;
			i++;
		end
		repeat (settle) @(posedge ref_clk);
		#1;
		chk(status_word_q & SMASK, exp);
		chk(16'({power_on_q, quick_stop_q}), 16'({exp[1] && !exp[3], exp == 16'h0007}));
	endtask

	task automatic cmd(input logic [15:0] c, input logic [15:0] exp);
		host.access(1'b1, 16'h6040, c);
		wait_state(exp, 6);
	endtask

	task automatic do_reset;
		resetn = 1'b0;
		repeat (16) @(posedge ref_clk);
		#1;
		chk(status_word_q, 16'h0000);
		resetn = 1'b1;
	endtask

	task automatic results;
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		resetn = 1'b0;
		tpdo_enable_opt = 1'b1;
		auto_enable_opt = 1'b0;
		brake_io_sel = 3'h5;
		brake_release_level = 1'b1;
		brake_activate_ms = 16'h0002;
		brake_release_ms = 16'h0002;
		io_in = 7'h00;
		io_out_mask = 7'h01;
		limit_enable = 2'h0;
		fault_in = 1'b0;
		homing_done = 1'b0;
		pos_error_mag = 16'h0000;
		max_pos_error = 16'h00ff;
		do_reset();
		wait_state(16'h0040, 6);
		chk(16'(tpdo_active_q), 16'h0001);
		host.access(1'b0, 16'h6041, 16'h0000);
		chk(obj_rdata_q, 16'h0240);
		for (int r = 0; r < 16; r++) begin
			cmd(rows[r][31:16], rows[r][15:0]);
		end
		// Brake line and masked line 1 must ignore the out word
		host.access(1'b1, 16'h60fe, 16'h00fe);
		@(posedge ref_clk);
		#1;
		chk(16'(io_out_q), 16'h006e);
		host.access(1'b1, 16'h6060, 16'h00ff);
		host.access(1'b0, 16'h6061, 16'h0000);
		chk(obj_rdata_q, 16'h00ff);
		chk(16'(encoder_follow_q), 16'h0001);
		chk(16'(mode_display_q), 16'h00ff);
		host.access(1'b0, 16'h1234, 16'h0000);
		chk(obj_rdata_q, 16'h0000);
		homing_done = 1'b1;
		io_in = 7'h04;
		pos_error_mag = 16'h0100;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(16'(status_word_q[14]), 16'h0001);
		chk(16'(home_switch_q), 16'h0001);
		chk(16'(motion_error_q), 16'h0001);
		pos_error_mag = 16'h00ff;
		io_in = 7'h00;
		repeat (3) @(posedge ref_clk);
		#1;
		chk(16'(motion_error_q), 16'h0000);
		cmd(16'h0006, 16'h0021);
		cmd(16'h0007, 16'h0023);
		cmd(16'h000f, 16'h0027);
		chk(16'({io_out_q[5], motion_allowed_q, drive_enable}), 16'h0007);
		cmd(16'h037f, 16'h0027);
		chk(16'({halt_q, mode_ctrl_q}), 16'h001f);
		cmd(16'hfc0f, 16'h0027);
		chk(16'({halt_q, mode_ctrl_q}), 16'h0000);
		// Brake must hold before the drive drops
		host.access(1'b1, 16'h6040, 16'h0007);
		for (int i = 0; i < 50 && io_out_q[5] !== 1'b0; i++) begin
			@(posedge ref_clk);
			#1;
		end
		chk(16'({io_out_q[5], drive_enable}), 16'h0001);
		wait_state(16'h0023, 6);
		cmd(16'h000f, 16'h0027);
		fault_in = 1'b1;
		wait_state(16'h000f, 0);
		wait_state(16'h0008, 6);
		fault_in = 1'b0;
		cmd(16'h0080, 16'h0040);
		fault_in = 1'b1;
		repeat (3) @(posedge ref_clk);
		#1;
		fault_in = 1'b0;
		wait_state(16'h0008, 20);
		cmd(16'h0000, 16'h0008);
		cmd(16'h0080, 16'h0040);
		limit_enable = 2'h1;
		io_in = 7'h01;
		cmd(16'h0006, 16'h0021);
		cmd(16'h0007, 16'h0023);
		host.access(1'b1, 16'h6040, 16'h000f);
		wait_state(16'h0008, 6);
		limit_enable = 2'h0;
		io_in = 7'h00;
		tpdo_enable_opt = 1'b0;
		auto_enable_opt = 1'b1;
		do_reset();
		wait_state(16'h0027, 6);
		chk(16'(tpdo_active_q), 16'h0000);
		// No brake line: line 5 is a plain output and enabling needs no wait
		brake_io_sel = 3'h0;
		host.access(1'b1, 16'h60fe, 16'h00fe);
		@(posedge ref_clk);
		#1;
		chk(16'(io_out_q), 16'h007e);
		cmd(16'h0006, 16'h0021);
		cmd(16'h0007, 16'h0023);
		cmd(16'h000f, 16'h0027);
		chk(16'({io_out_q[5], motion_allowed_q, drive_enable}), 16'h0007);
		results();
	end
endmodule
